// ---- hw/csc_pkg.sv ----
// Constants and carrier types for the charger supervisor control block.
// Assumes one 125 MHz clock and comparator results that are already synchronous.
package csc_pkg;
	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int FAST_OCP_US = 100;
	localparam int FAST_OCP_CYCLES = FAST_OCP_US * CLK_MHZ;
	localparam int IRQ_PULSE_US = 256;
	localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_US * CLK_MHZ;
	localparam int SLOW_OCP_MS = 50;
	localparam int HICCUP_OFF_MS = 100;
	localparam int HICCUP_ON_MS = 1;
	localparam int DLY_SHORT_MS = 20;
	localparam int DLY_LONG_MS = 10000;
	localparam int SHIP_EXIT_MS = 1000;
	localparam int PB_RESET_MS = 10000;
	localparam int RESET_OFF_MS = 350;
	localparam int BAT_OVP_PERSIST_MS = 1;
	localparam int TRICKLE_MS = 3600000;
	localparam int PRECHG_MS = 7200000;
	localparam int FASTCHG_MS = 43200000;
	localparam int WD_CODE1_MS = 50000;
	localparam int WD_CODE2_MS = 100000;
	localparam int WD_CODE3_MS = 200000;
	// ************************************************
	// Encodings
	// ************************************************
	localparam logic [1:0] CTL_NORMAL = 2'h0;
	localparam logic [1:0] CTL_SHIP = 2'h2;
	localparam logic [1:0] CTL_RESET = 2'h3;
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] STAGE_TRICKLE = 2'h0;
	localparam logic [1:0] STAGE_PRE = 2'h1;
	localparam logic [2:0] SRC_NONE = 3'h0;
	typedef enum logic [2:0] {
		ST_NORMAL, ST_DELAY, ST_SHIP_WAIT, ST_SHIP, ST_RST_OFF, ST_UVLO, ST_HIC_OFF, ST_HIC_ON
	} csc_state_t;
	typedef struct packed {
		logic battery_fault;
		logic input_fault;
		logic input_overvoltage;
		logic system_voltage_fault;
		logic system_short;
		logic thermal_regulation;
		logic thermal_shutdown;
		logic host_timeout;
	} csc_status_t;
	typedef struct packed {
		logic battery_fault;
		logic input_fault;
		logic system_voltage_fault;
		logic system_short;
		logic thermal_regulation;
		logic thermal_shutdown;
		logic host_timeout;
	} csc_event_t;
	typedef struct packed {
		logic input_ovp;
		logic sys_ovp;
		logic sys_short;
		logic bat_ovp;
		logic sleep_cmp;
		logic poor_source;
		logic thermal_reg;
		logic thermal_shut;
		logic bat_uv;
		logic bat_peak_over;
		logic bat_switch_ocp_over;
	} csc_sense_t;
endpackage : csc_pkg

// ---- hw/csc_top.sv ----
// Supervisor for a single-cell buck charger: switch modes, protections, host watchdog.
// Assumes synchronous comparator levels and strobes, and an outside register file
// that acts on the default-restore and halve pulses.
`timescale 1ns/100ps
// Function
// (R1) Control write 10, no adapter: ship mode
// (R2) Pushbutton hold or adapter exits ship, defaults
// (R3) Ship with adapter: switch off or wait
// (R4) Reset trigger gated by setting or no adapter
// (R5) Register reset waits delay, pushbutton immediate
// (R6) Battery undervoltage opens switch, recovery restores defaults
// (R7) Two-level overcurrent trips into hiccup
// (R8) Hiccup clears status off, re-evaluates on
// (R9) Input overvoltage stops converter, discharges input
// (R10) System overvoltage stops converter, pulls down
// (R11) System short forces pulse-frequency operation
// (R12) Battery overvoltage opens switch, loads battery
// (R13) Sleep comparator stops converter, power-good high
// (R14) Poor source: source none, battery-only
// (R15) Thermal regulation lowers current, halves timer
// (R16) Thermal shutdown turns converter and switch off
// (R17) Default mode sets timeout status, event, pulse
// (R18) Reset starts in default mode, expired
// (R19) Default mode safety timers stop charging
// (R20) Register write enters host mode, kick restarts
// (R21) Watchdog expiry: default mode, halve, restore
// (R22) Register reset bit restores defaults, self-clears
// (R23) Interrupt pulses low; events latch until read
// (R24) Delay select chooses 20 ms or 10 s
// (R25) Free-running timebase restarts with defaults
module csc_top
	import csc_pkg::*;
#(
	parameter int MS_CYCLES = TICK_CYCLES,
	parameter int FAST_CYCLES = FAST_OCP_CYCLES,
	parameter int IRQ_CYCLES = IRQ_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Analog sense levels
	input wire logic adapter_present,
	input wire logic forward_mode,
	input wire csc_sense_t sense,
	input wire logic pushbutton_n,
	input wire logic [2:0] attach_source_type,
	input wire logic charge_active,
	input wire logic [1:0] charge_stage,
	// Register strobes and settings
	input wire logic register_write,
	input wire logic control_write,
	input wire logic [1:0] control_value,
	input wire logic switch_action_with_input,
	input wire logic switch_off_delay_select,
	input wire logic host_timer_kick,
	input wire logic [1:0] watchdog_period,
	input wire logic register_reset_write,
	input wire logic host_timeout_irq_block,
	input wire logic flag_read,
	// Power path controls
	output logic battery_switch_on,
	output logic serial_enable,
	output logic converter_on,
	output logic input_discharge_on,
	output logic system_load_on,
	output logic battery_load_on,
	output logic pfm_forced,
	output logic power_good_n,
	output logic [2:0] input_source_type,
	output logic battery_only,
	output logic charge_current_reduced,
	output logic charge_enable,
	// Register side
	output logic [1:0] battery_switch_control,
	output logic register_reset_bit,
	output logic restore_defaults,
	output logic watchdog_defaults,
	output logic charge_current_halve,
	output csc_status_t status,
	output csc_event_t events,
	output logic irq_n
);
	// ************************************************
	// Elaboration checks
	// ************************************************
	if (MS_CYCLES < 2 || FAST_CYCLES < 2 || FAST_CYCLES > 65535 || IRQ_CYCLES < 2 ||
			IRQ_CYCLES > 65535) begin : g_bad
		$error("cycle counts out of range");
	end

	typedef struct packed {
		csc_state_t st;
		logic [1:0] ctl;
		logic pend_reset;
		logic [31:0] st_ms;
		logic [15:0] pb_ms;
		logic pb_done;
		logic host_mode;
		logic [31:0] wd_ms;
		logic [31:0] safe_ms;
		logic [1:0] stage_q;
		logic safe_expired;
		logic [15:0] fast_cnt;
		logic [7:0] slow_ms;
		logic [7:0] ovp_ms;
		logic ocp_stat;
		csc_status_t stat;
		csc_event_t evt;
		logic [15:0] irq_cnt;
		logic irq_n;
		logic sw_on;
		logic serial_en;
		logic conv_on;
		logic pg_n;
		logic defaults;
		logic wd_defaults;
		logic halve;
		logic rst_bit;
	} csc_core_t;

	// Power-on state: default mode, watchdog expired, power-up pulse running.
	localparam csc_core_t CORE_POR = '{st: ST_NORMAL, ctl: CTL_NORMAL, pend_reset: 1'b0,
		st_ms: 32'h0000_0000, pb_ms: 16'h0000, pb_done: 1'b0, host_mode: 1'b0,
		wd_ms: 32'h0000_0000, safe_ms: 32'h0000_0000, stage_q: STAGE_TRICKLE,
		safe_expired: 1'b0, fast_cnt: 16'h0000, slow_ms: 8'h00, ovp_ms: 8'h00,
		ocp_stat: 1'b0, stat: 8'h01, evt: 7'h01, irq_cnt: 16'h0000, irq_n: 1'b0,
		sw_on: 1'b1, serial_en: 1'b1, conv_on: 1'b0, pg_n: 1'b1, defaults: 1'b0,
		wd_defaults: 1'b0, halve: 1'b0, rst_bit: 1'b0};

	// ************************************************
	// Timebase
	// ************************************************
	logic [31:0] tb_cnt;
	logic [31:0] next_tb_cnt;
	logic tick;
	logic next_tick;
	logic half;
	logic next_half;
	csc_core_t core;
	csc_core_t next_core;

	always_comb begin
		next_tb_cnt = tb_cnt + 32'h0000_0001;
		next_tick = 1'b0;
		next_half = half;
		if (tb_cnt == 32'(MS_CYCLES - 1)) begin
			next_tb_cnt = 32'h0000_0000;
			next_tick = 1'b1;
			next_half = ~half;
		end
		if (core.defaults) begin
			next_tb_cnt = 32'h0000_0000; // R25
			next_tick = 1'b0;
			next_half = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tb_cnt <= 32'h0000_0000;
			tick <= 1'b0;
			half <= 1'b0;
		end else begin
			tb_cnt <= next_tb_cnt;
			tick <= next_tick;
			half <= next_half;
		end
	end

	// ************************************************
	// Supervisor core
	// ************************************************
	logic pb_ship;
	logic pb_rst;
	logic may_rst;
	logic ocp_trip;
	logic delay_done;
	logic [31:0] wd_limit;
	logic [31:0] safe_limit;
	csc_event_t rise;

	always_comb begin
		next_core = core;
		next_core.defaults = 1'b0;
		next_core.wd_defaults = 1'b0;
		next_core.halve = 1'b0;
		next_core.rst_bit = 1'b0;
		if (tick) begin
			next_core.st_ms = core.st_ms + 32'h0000_0001;
		end
		if (pushbutton_n) begin
			next_core.pb_ms = 16'h0000;
			next_core.pb_done = 1'b0;
		end else if (tick && core.pb_ms != 16'hffff) begin
			next_core.pb_ms = core.pb_ms + 16'h0001;
		end
		pb_ship = !pushbutton_n && core.pb_ms >= 16'(SHIP_EXIT_MS);
		pb_rst = !pushbutton_n && !core.pb_done && core.pb_ms >= 16'(PB_RESET_MS);
		may_rst = switch_action_with_input || !adapter_present; // R4
		delay_done = core.st_ms >= (switch_off_delay_select ? 32'(DLY_LONG_MS) :
			32'(DLY_SHORT_MS)); // R24
		// Overcurrent timers run only while the switch conducts; both restart on turn-on.
		if (sense.bat_peak_over && core.sw_on) begin
			next_core.fast_cnt = core.fast_cnt + 16'h0001;
		end else begin
			next_core.fast_cnt = 16'h0000;
		end
		if (!(sense.bat_switch_ocp_over && core.sw_on)) begin
			next_core.slow_ms = 8'h00;
		end else if (tick) begin
			next_core.slow_ms = core.slow_ms + 8'h01;
		end
		ocp_trip = (core.fast_cnt >= 16'(FAST_CYCLES - 1) && sense.bat_peak_over) ||
			(core.slow_ms >= 8'(SLOW_OCP_MS)); // R7
		case (core.st)
			ST_NORMAL: begin
				if (control_write && control_value == CTL_SHIP) begin
					next_core.ctl = CTL_SHIP; // R1
					next_core.pend_reset = 1'b0;
					next_core.st = ST_DELAY;
					next_core.st_ms = 32'h0000_0000;
				end else if (control_write && control_value == CTL_RESET && may_rst) begin
					next_core.ctl = CTL_RESET; // R5
					next_core.pend_reset = 1'b1;
					next_core.st = ST_DELAY;
					next_core.st_ms = 32'h0000_0000;
				end else if (control_write) begin
					next_core.ctl = CTL_NORMAL;
				end else if (pb_rst && may_rst) begin
					next_core.pb_done = 1'b1; // R5
					next_core.st = ST_RST_OFF;
					next_core.st_ms = 32'h0000_0000;
				end else if (sense.bat_uv && !adapter_present) begin
					next_core.st = ST_UVLO; // R6
				end else if (ocp_trip) begin
					next_core.ocp_stat = 1'b1; // R7
					next_core.st = ST_HIC_OFF;
					next_core.st_ms = 32'h0000_0000;
				end
			end
			ST_DELAY: begin
				if (control_write && control_value == CTL_NORMAL) begin
					next_core.ctl = CTL_NORMAL;
					next_core.st = ST_NORMAL;
				end else if (delay_done) begin
					next_core.st_ms = 32'h0000_0000;
					if (core.pend_reset) begin
						next_core.st = ST_RST_OFF;
					end else if (!adapter_present) begin
						next_core.st = ST_SHIP; // R1
					end else begin
						next_core.st = ST_SHIP_WAIT; // R3
					end
				end
			end
			ST_SHIP_WAIT: begin
				if (control_write && control_value == CTL_NORMAL) begin
					next_core.ctl = CTL_NORMAL; // R3
					next_core.st = ST_NORMAL;
				end else if (!adapter_present) begin
					next_core.st = ST_SHIP;
				end
			end
			ST_SHIP, ST_UVLO: begin
				if ((core.st == ST_SHIP && (pb_ship || adapter_present)) ||
						(core.st == ST_UVLO && (!sense.bat_uv || adapter_present))) begin
					next_core = CORE_POR; // R2 R6
					next_core.defaults = 1'b1;
				end
			end
			ST_RST_OFF: begin
				if (core.st_ms >= 32'(RESET_OFF_MS)) begin
					next_core.ctl = CTL_NORMAL;
					next_core.st = ST_NORMAL;
				end
			end
			ST_HIC_OFF: begin
				next_core.ocp_stat = 1'b0; // R8
				if (core.st_ms >= 32'(HICCUP_OFF_MS)) begin
					next_core.st = ST_HIC_ON;
					next_core.st_ms = 32'h0000_0000;
				end
			end
			ST_HIC_ON: begin
				if (ocp_trip || (core.st_ms >= 32'(HICCUP_ON_MS) &&
						(sense.bat_peak_over || sense.bat_switch_ocp_over))) begin
					next_core.ocp_stat = 1'b1; // R8
					next_core.st = ST_HIC_OFF;
					next_core.st_ms = 32'h0000_0000;
				end else if (core.st_ms >= 32'(HICCUP_ON_MS)) begin
					next_core.st = ST_NORMAL;
				end
			end
			default: begin
				next_core.st = ST_NORMAL;
			end
		endcase
		// Watchdog and register reset; writes are lost while the serial port is off.
		case (watchdog_period)
			2'h1: wd_limit = 32'(WD_CODE1_MS);
			2'h2: wd_limit = 32'(WD_CODE2_MS);
			default: wd_limit = 32'(WD_CODE3_MS);
		endcase
		if (core.serial_en && (register_write || host_timer_kick)) begin
			next_core.host_mode = 1'b1; // R20
			next_core.wd_ms = 32'h0000_0000;
		end else if (core.host_mode && watchdog_period != WD_OFF && tick) begin
			next_core.wd_ms = core.wd_ms + 32'h0000_0001;
			if (core.wd_ms >= wd_limit - 32'h0000_0001) begin
				next_core.host_mode = 1'b0; // R21
				next_core.wd_defaults = 1'b1;
				next_core.halve = 1'b1;
			end
		end
		if (core.serial_en && register_reset_write) begin
			next_core.rst_bit = 1'b1; // R22
			next_core.defaults = 1'b1;
			next_core.wd_ms = 32'h0000_0000;
			next_core.safe_ms = 32'h0000_0000;
		end
		// Safety timer: default mode only, half rate under thermal regulation.
		case (charge_stage)
			STAGE_TRICKLE: safe_limit = 32'(TRICKLE_MS);
			STAGE_PRE: safe_limit = 32'(PRECHG_MS);
			default: safe_limit = 32'(FASTCHG_MS);
		endcase
		next_core.stage_q = charge_stage;
		if (charge_stage != core.stage_q || core.defaults) begin
			next_core.safe_ms = 32'h0000_0000;
			next_core.safe_expired = 1'b0;
		end else if (!core.host_mode && charge_active && !core.safe_expired && tick &&
				(!sense.thermal_reg || half)) begin
			next_core.safe_ms = core.safe_ms + 32'h0000_0001; // R15 R19
			if (core.safe_ms >= safe_limit - 32'h0000_0001) begin
				next_core.safe_expired = 1'b1; // R19
			end
		end
		if (!sense.bat_ovp) begin
			next_core.ovp_ms = 8'h00;
		end else if (tick && core.ovp_ms != 8'hff) begin
			next_core.ovp_ms = core.ovp_ms + 8'h01;
		end
		// Status follows the live conditions.
		next_core.stat.battery_fault = next_core.ocp_stat ||
			(sense.bat_ovp && core.ovp_ms >= 8'(BAT_OVP_PERSIST_MS)); // R12
		next_core.stat.input_fault = sense.input_ovp || sense.sleep_cmp; // R9 R13
		next_core.stat.input_overvoltage = sense.input_ovp; // R9
		next_core.stat.system_voltage_fault = sense.sys_ovp && forward_mode; // R10
		next_core.stat.system_short = sense.sys_short; // R11
		next_core.stat.thermal_regulation = sense.thermal_reg; // R15
		next_core.stat.thermal_shutdown = sense.thermal_shut; // R16
		next_core.stat.host_timeout = !next_core.host_mode; // R17
		rise.battery_fault = next_core.stat.battery_fault && !core.stat.battery_fault;
		rise.input_fault = next_core.stat.input_fault && !core.stat.input_fault;
		rise.system_voltage_fault = next_core.stat.system_voltage_fault &&
			!core.stat.system_voltage_fault;
		rise.system_short = next_core.stat.system_short && !core.stat.system_short;
		rise.thermal_regulation = next_core.stat.thermal_regulation &&
			!core.stat.thermal_regulation;
		rise.thermal_shutdown = next_core.stat.thermal_shutdown && !core.stat.thermal_shutdown;
		rise.host_timeout = next_core.stat.host_timeout && !core.stat.host_timeout; // R17
		// A new event in the read cycle survives the clear.
		next_core.evt = (flag_read ? 7'h00 : next_core.evt) | rise; // R23
		if (!core.irq_n) begin
			next_core.irq_cnt = core.irq_cnt + 16'h0001;
			if (core.irq_cnt >= 16'(IRQ_CYCLES - 1)) begin
				next_core.irq_n = 1'b1; // R23
			end
		end
		if ((rise & 7'h7e) != 7'h00 || (rise.host_timeout && !host_timeout_irq_block)) begin
			next_core.irq_n = 1'b0; // R17 R21 R23
			next_core.irq_cnt = 16'h0000;
		end
		// Power path decisions from the next state.
		next_core.sw_on = !(next_core.st inside {ST_SHIP, ST_RST_OFF, ST_UVLO, ST_HIC_OFF}) &&
			!(next_core.st == ST_SHIP_WAIT && switch_action_with_input) && // R3
			!sense.bat_ovp && !sense.thermal_shut; // R12 R16
		next_core.serial_en = !(next_core.st inside {ST_SHIP, ST_UVLO}); // R1 R6
		next_core.conv_on = adapter_present && !sense.input_ovp && !sense.sleep_cmp &&
			!(sense.sys_ovp && forward_mode) && !sense.poor_source && // R9 R10 R13 R14
			!sense.thermal_shut && !(next_core.st inside {ST_RST_OFF, ST_SHIP}); // R16
		next_core.pg_n = !adapter_present || sense.sleep_cmp || sense.poor_source; // R13 R14
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			core <= CORE_POR; // R18
		end else begin
			core <= next_core;
		end
	end

	// ************************************************
	// Registered side outputs
	// ************************************************
	logic next_in_dis;
	logic next_sys_load;
	logic next_chg_en;
	logic [2:0] next_src;

	always_comb begin
		next_in_dis = sense.input_ovp; // R9
		next_sys_load = sense.sys_ovp && forward_mode; // R10
		next_chg_en = !next_core.safe_expired && !sense.bat_ovp; // R12 R19
		next_src = (sense.poor_source || !adapter_present) ? SRC_NONE :
			attach_source_type; // R14
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			input_discharge_on <= 1'b0;
			system_load_on <= 1'b0;
			battery_load_on <= 1'b0;
			pfm_forced <= 1'b0;
			input_source_type <= SRC_NONE;
			battery_only <= 1'b1;
			charge_current_reduced <= 1'b0;
			charge_enable <= 1'b1;
		end else begin
			input_discharge_on <= next_in_dis;
			system_load_on <= next_sys_load;
			battery_load_on <= sense.bat_ovp; // R12
			pfm_forced <= sense.sys_short; // R11
			input_source_type <= next_src;
			battery_only <= sense.poor_source || !adapter_present; // R14
			charge_current_reduced <= sense.thermal_reg; // R15
			charge_enable <= next_chg_en;
		end
	end

	assign battery_switch_on = core.sw_on;
	assign serial_enable = core.serial_en;
	assign converter_on = core.conv_on;
	assign power_good_n = core.pg_n;
	assign battery_switch_control = core.ctl;
	assign register_reset_bit = core.rst_bit;
	assign restore_defaults = core.defaults;
	assign watchdog_defaults = core.wd_defaults;
	assign charge_current_halve = core.halve;
	assign status = core.stat;
	assign events = core.evt;
	assign irq_n = core.irq_n;
endmodule : csc_top

// ---- tb/csc_props.sv ----
// Assertion checker for the charger supervisor control block.
// Assumes it is bound into csc_top and sees only that module's ports.
`timescale 1ns/100ps
module csc_props
	import csc_pkg::*;
#(
	parameter int IRQ_CYCLES = IRQ_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Sense and strobes
	input wire logic adapter_present,
	input wire csc_sense_t sense,
	input wire logic register_write,
	input wire logic control_write,
	input wire logic [1:0] control_value,
	input wire logic register_reset_write,
	input wire logic flag_read,
	// Outputs watched
	input wire logic battery_switch_on,
	input wire logic serial_enable,
	input wire logic converter_on,
	input wire logic input_discharge_on,
	input wire logic pfm_forced,
	input wire logic [1:0] battery_switch_control,
	input wire logic register_reset_bit,
	input wire logic restore_defaults,
	input wire logic watchdog_defaults,
	input wire logic charge_current_halve,
	input wire csc_status_t status,
	input wire csc_event_t events,
	input wire logic irq_n
);
	// ********
	// Interrupt low-time counter
	// ********
	// Free-running, so a pulse begun in reset counts in full.
	int lo_cnt;
	int next_lo_cnt;
	always_comb begin
		next_lo_cnt = irq_n ? 0 : lo_cnt + 1;
	end
	always_ff @(posedge clk_sys) begin
		lo_cnt <= next_lo_cnt;
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	rst_bit_pulse_a: assert property (register_reset_write && serial_enable |=>
		register_reset_bit ##1 !register_reset_bit) else $error("reset bit width");
	irq_width_a: assert property ($rose(irq_n) |-> lo_cnt >= IRQ_CYCLES)
		else $error("irq pulse short");
	event_hold_a: assert property (|($past(events) & ~events) |->
		$past(flag_read) || restore_defaults || $past(restore_defaults))
		else $error("event lost");
	ovp_stop_a: assert property (sense.input_ovp |=> !converter_on)
		else $error("converter on in ovp");
	discharge_cause_a: assert property (input_discharge_on |-> $past(sense.input_ovp))
		else $error("stray discharge");
	short_pfm_a: assert property (sense.sys_short && adapter_present |=> pfm_forced)
		else $error("no forced pfm");
	tshut_off_a: assert property (sense.thermal_shut |=>
		!battery_switch_on && status.thermal_shutdown) else $error("no shutdown");
	serial_gate_a: assert property (!serial_enable |-> !battery_switch_on)
		else $error("switch on in ship");
	ship_take_a: assert property (control_write && serial_enable && control_value == CTL_SHIP
		&& battery_switch_control == CTL_NORMAL |=> battery_switch_control == CTL_SHIP)
		else $error("ship lost");
	wd_pair_a: assert property (watchdog_defaults |-> charge_current_halve)
		else $error("no halve");
	host_mode_a: assert property (register_write && serial_enable |=> !status.host_timeout)
		else $error("no host mode");
endmodule : csc_props
bind csc_top csc_props #(.IRQ_CYCLES(IRQ_CYCLES)) u_csc_props (.*);

// ---- tb/csc_host_model.sv ----
// Host processor model driving the register strobes.
// Assumes strobes are taken on a rising edge.
`timescale 1ns/100ps
module csc_host_model
	import csc_pkg::*;
#(
	parameter int KICK_CYCLES = 1000
) (
	// Clock
	input wire logic clk_sys,
	// Register strobes
	output logic register_write,
	output logic control_write,
	output logic [1:0] control_value,
	output logic host_timer_kick,
	output logic [1:0] watchdog_period,
	output logic register_reset_write,
	output logic flag_read
);
	int kick_cnt;
	initial begin
		{register_write, control_write, register_reset_write, flag_read} = 4'h0;
		control_value = CTL_NORMAL;
		watchdog_period = 2'h1;
	end
	// Kicks well inside the shortest watchdog period.
	always @(posedge clk_sys) begin
		kick_cnt <= (kick_cnt == KICK_CYCLES) ? 0 : kick_cnt + 1;
		host_timer_kick <= (kick_cnt == KICK_CYCLES);
	end
	task automatic strobe(input logic wr, input logic ctl, input logic [1:0] val,
		input logic rr, input logic rd);
		@(posedge clk_sys);
		{register_write, control_write, control_value, register_reset_write, flag_read} <=
			{wr, ctl, val, rr, rd};
		@(posedge clk_sys);
		{register_write, control_write, register_reset_write, flag_read} <= 4'h0;
	endtask : strobe
endmodule : csc_host_model

// ---- tb/csc_top_bench.sv ----
// Self-checking bench for the charger supervisor control block.
// Assumes the design, host model and bound checker are compiled first.
`timescale 1ns/100ps
module csc_top_bench;
	import csc_pkg::*;
	localparam int MS = 10;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic adapter_present = 1'b0, charge_active = 1'b0, switch_action_with_input = 1'b0;
	logic forward_mode = 1'b1, pushbutton_n = 1'b1;
	logic switch_off_delay_select = 1'b0, host_timeout_irq_block = 1'b0;
	logic [1:0] charge_stage = 2'h0;
	logic [2:0] attach_source_type = 3'h1;
	csc_sense_t sense = '0;
	logic register_write, control_write, host_timer_kick, register_reset_write, flag_read;
	logic [1:0] control_value, watchdog_period, battery_switch_control;
	logic battery_switch_on, serial_enable, converter_on, power_good_n, battery_only;
	logic restore_defaults, irq_n;
	logic [2:0] input_source_type;
	csc_status_t status;
	csc_event_t events;
	wire [10:0] path_seen = {status, converter_on, battery_switch_on, power_good_n};
	int bad_count = 0, total_checks = 0, cycles = 0, seed = 33, hold;
	int fault_bits[7] = '{10, 9, 8, 7, 6, 4, 3};
	csc_top #(.MS_CYCLES(MS), .FAST_CYCLES(4), .IRQ_CYCLES(8)) u_csc_top (
		.*,
		.input_discharge_on(),
		.system_load_on(),
		.battery_load_on(),
		.pfm_forced(),
		.charge_current_reduced(),
		.charge_enable(),
		.register_reset_bit(),
		.watchdog_defaults(),
		.charge_current_halve()
	);
	csc_host_model u_csc_host_model (.*);
	always #4 clk_sys = ~clk_sys;
	// ********
	// Helpers
	// ********
	task automatic print_verdict();
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic wait_restore(input int limit, output int n);
		for (n = 0; n < limit && restore_defaults !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
	endtask : wait_restore
	task automatic ctl_write(input logic [1:0] v);
		u_csc_host_model.strobe(1'b1, 1'b1, v, 1'b0, 1'b0);
	endtask : ctl_write
	task automatic read_flags();
		u_csc_host_model.strobe(1'b0, 1'b0, CTL_NORMAL, 1'b0, 1'b1);
	endtask : read_flags
	// Expected path_seen for one held fault.
	function automatic logic [10:0] fexp(input int bit_no);
		case (bit_no)
			10: return {8'h60, 3'b010};
			9: return {8'h10, 3'b010};
			8: return {8'h08, 3'b110};
			7: return {8'h80, 3'b100};
			6: return {8'h40, 3'b011};
			4: return {8'h04, 3'b110};
			3: return {8'h02, 3'b000};
			default: return {8'h00, 3'b110};
		endcase
	endfunction : fexp
	// Ceiling is two and a half times the planned run.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ********
	// Main sequence
	// ********
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cyc(2);
		chk("power_up", {status, events, irq_n, battery_switch_on, serial_enable, battery_only,
			input_source_type}, {8'h01, 7'h01, 4'h7, 3'h0});
		read_flags();
		cyc(1);
		chk("first_read", events, 7'h00);
		u_csc_host_model.strobe(1'b0, 1'b0, CTL_NORMAL, 1'b1, 1'b0);
		ctl_write(CTL_NORMAL);
		cyc(1);
		chk("host_mode", status.host_timeout, 1'b0);
		@(posedge clk_sys);
		attach_source_type <= 3'({$random(seed)} % 7 + 1);
		adapter_present <= 1'b1;
		cyc(5);
		chk("baseline", path_seen, fexp(0));
		foreach (fault_bits[k]) begin
			hold = 20 + {$random(seed)} % 16;
			@(posedge clk_sys);
			sense[fault_bits[k]] <= 1'b1;
			charge_stage <= 2'({$random(seed)} % 4);
			charge_active <= 1'({$random(seed)} % 2);
			cyc(hold);
			chk("fault_on", path_seen, fexp(fault_bits[k]));
			@(posedge clk_sys);
			sense[fault_bits[k]] <= 1'b0;
			cyc(5);
			chk("fault_off", path_seen, fexp(0));
		end
		chk("events", events, 7'h7E);
		read_flags();
		cyc(1);
		chk("events_read", events, 7'h00);
		@(posedge clk_sys);
		sense.poor_source <= 1'b1;
		cyc(3);
		chk("poor_on", {input_source_type, battery_only, power_good_n}, 5'h03);
		@(posedge clk_sys);
		sense.poor_source <= 1'b0;
		cyc(5);
		chk("poor_off", input_source_type, attach_source_type);
		ctl_write(CTL_RESET);
		cyc(2);
		chk("reset_refused", {battery_switch_control, battery_switch_on}, 3'b001);
		@(posedge clk_sys);
		switch_action_with_input <= 1'b1;
		ctl_write(CTL_RESET);
		cyc((DLY_SHORT_MS - 1) * MS - 3);
		chk("reset_delay", battery_switch_on, 1'b1);
		cyc(MS + 16);
		chk("reset_off", {battery_switch_on, converter_on}, 2'b00);
		cyc(RESET_OFF_MS * MS + 30);
		chk("reset_done", {battery_switch_on, battery_switch_control}, 3'b100);
		@(posedge clk_sys);
		switch_off_delay_select <= 1'b1;
		ctl_write(CTL_SHIP);
		cyc(30 * MS);
		chk("long_delay", battery_switch_on, 1'b1);
		ctl_write(CTL_NORMAL);
		cyc(2);
		chk("ship_abort", {battery_switch_control, battery_switch_on}, 3'b001);
		@(posedge clk_sys);
		switch_off_delay_select <= 1'b0;
		switch_action_with_input <= 1'b0;
		ctl_write(CTL_SHIP);
		cyc(30 * MS);
		chk("ship_wait", {battery_switch_control, battery_switch_on}, 3'b101);
		@(posedge clk_sys);
		adapter_present <= 1'b0;
		cyc(MS + 5);
		chk("ship_entry", {battery_switch_on, serial_enable}, 2'b00);
		@(posedge clk_sys);
		pushbutton_n <= 1'b0;
		wait_restore(SHIP_EXIT_MS * MS + 50, hold);
		chk("ship_exit_time", {hold >= (SHIP_EXIT_MS - 1) * MS, restore_defaults}, 2'b11);
		@(posedge clk_sys);
		pushbutton_n <= 1'b1;
		cyc(2);
		chk("ship_exit", {battery_switch_on, serial_enable, status.host_timeout}, 3'b111);
		@(posedge clk_sys);
		sense.bat_peak_over <= 1'b1;
		cyc(8);
		@(posedge clk_sys);
		sense.bat_peak_over <= 1'b0;
		cyc(2);
		chk("ocp_trip", {events.battery_fault, status.battery_fault, battery_switch_on},
			3'b100);
		cyc(50 * MS);
		chk("hiccup_off", battery_switch_on, 1'b0);
		cyc(60 * MS);
		chk("hiccup_end", battery_switch_on, 1'b1);
		@(posedge clk_sys);
		sense.bat_uv <= 1'b1;
		cyc(3);
		chk("uvlo", {battery_switch_on, serial_enable}, 2'b00);
		@(posedge clk_sys);
		sense.bat_uv <= 1'b0;
		adapter_present <= 1'b1;
		wait_restore(50, hold);
		chk("uvlo_exit", restore_defaults, 1'b1);
		print_verdict();
	end
endmodule : csc_top_bench
